// ---- verilog/led_pwm_pkg.sv ----
// Shared register map, field layout and carrier types of the LED pulse-width block
package led_pwm_pkg;
  localparam int NUM_CH = 36;
  localparam int NUM_GROUPS = 6;
  localparam int FORCE_GROUPS = 3;
  localparam logic [7:0] OFS_DUTY_FIRST = 8'h01;
  localparam logic [7:0] OFS_DUTY_LAST = 8'h48;
  localparam logic [7:0] OFS_APPLY = 8'h49;
  localparam logic [7:0] OFS_SCALE_FIRST = 8'h4a;
  localparam logic [7:0] OFS_SCALE_LAST = 8'h6d;
  localparam logic [7:0] OFS_GLOBAL = 8'h6e;
  localparam logic [7:0] OFS_PHASE = 8'h70;
  localparam logic [7:0] OFS_DETECT = 8'h71;
  localparam logic [7:0] OFS_FAULT_FIRST = 8'h72;
  localparam logic [7:0] OFS_FAULT_TOP = 8'h76;
  localparam logic [7:0] OFS_THERMAL = 8'h77;
  localparam logic [7:0] OFS_SPREAD = 8'h78;
  localparam logic [7:0] OFS_SOFT_RESET = 8'h7f;
  localparam logic [7:0] TRIGGER_VALUE = 8'h00;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam int PHASE_ON_BIT = 7;
  localparam int THERM_FLAG_BIT = 4;
  localparam int DERATE_LSB = 6;
  localparam int FORCE_LSB = 5;
  localparam int SPREAD_EN_BIT = 4;
  localparam int SPREAD_RANGE_LSB = 2;
  localparam int SPREAD_PERIOD_LSB = 0;
  // Detect mode codes
  localparam logic [1:0] DET_SHORT = 2'h2;
  localparam logic [1:0] DET_OPEN = 2'h3;
  // Resolution codes and counter masks
  localparam logic [1:0] RES_8 = 2'h0;
  localparam logic [1:0] RES_10 = 2'h1;
  localparam logic [1:0] RES_12 = 2'h2;
  localparam logic [15:0] MASK_8 = 16'h00ff;
  localparam logic [15:0] MASK_10 = 16'h03ff;
  localparam logic [15:0] MASK_12 = 16'h0fff;
  localparam logic [15:0] MASK_16 = 16'hffff;
  // Thermal start points in degrees C
  localparam logic [7:0] TEMP_PT_0 = 8'd140;
  localparam logic [7:0] TEMP_PT_1 = 8'd120;
  localparam logic [7:0] TEMP_PT_2 = 8'd100;
  localparam logic [7:0] TEMP_PT_3 = 8'd90;
  // Derating factors out of 256 for 100, 75, 55 and 30 percent
  localparam logic [8:0] DERATE_F_0 = 9'd256;
  localparam logic [8:0] DERATE_F_1 = 9'd192;
  localparam logic [8:0] DERATE_F_2 = 9'd141;
  localparam logic [8:0] DERATE_F_3 = 9'd77;

  typedef struct packed {
    logic addr_load;
    logic wr;
    logic rd;
    logic [7:0] data;
  } reg_cmd_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } reg_rsp_t;
endpackage

// ---- verilog/led_pwm_current_regs.sv ----
// Register bank and per-channel pulse-width and current engine of the LED driver
//
// Notes on behaviour
// R01: Duty 16 bits, low odd, high even
// R02: 8-bit resolution ignores high duty byte
// R03: On fraction equals duty over N
// R04: Peak current is global times channel scale
// R05: Channel scale bytes at 4Ah to 6Dh
// R06: Writing 00h to 49h applies duty
// R07: Scale writes take effect immediately
// R08: Global current byte at 6Eh
// R09: Bit 7 of 70h enables phase delay
// R10: Phase bits pick 0 or 180 degrees
// R11: Detect mode: off, short, open
// R12: Only one fault kind held
// R13: Fault bits packed at 72h to 76h
// R14: Threshold code picks thermal start point
// R15: Thermal flag shows temperature over threshold
// R16: Derate code limits current when hot
// R17: Force-on bits drive twelve-channel groups full
// R18: Without force, duty stays below full
// R19: Bit 4 enables clock spreading
// R20: Range field selects spread deviation
// R21: Cycle field selects spread period
// R22: Writing 00h to 7Fh restores defaults
// R23: Resolution code selects 8/10/12/16 bits
// R24: Pointer increments after each data byte; writing 00h to 7Fh clears it
// R25: Output on while counter below duty
// R26: Phase bits delay six channel groups
`timescale 1ns/10ps
module led_pwm_current_regs
  import led_pwm_pkg::*;
#(
  parameter int CH_COUNT = 36
)
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  // Register command port from the serial slave
  input wire led_pwm_pkg::reg_cmd_t cmd_i,
  output led_pwm_pkg::reg_rsp_t rsp_o,
  // Settings held outside this block
  input wire logic [1:0] duty_resolution_i,
  // Analog sense inputs
  input wire logic [7:0] die_temp_i,
  input wire logic [CH_COUNT-1:0] open_det_i,
  input wire logic [CH_COUNT-1:0] short_det_i,
  // Channel drive
  output logic [CH_COUNT-1:0] pwm_o,
  output logic [CH_COUNT*16-1:0] current_code_o,
  // Oscillator spreading controls
  output logic spread_enable_o,
  output logic [1:0] spread_range_o,
  output logic [1:0] spread_period_o
);
  import led_pwm_pkg::*;

  if (CH_COUNT != NUM_CH)
  begin : g_bad_count
    $error("Channel count must match the fixed register map");
  end

  typedef struct packed {
    logic [7:0] ptr;
    logic [CH_COUNT-1:0][15:0] duty_pend;
    logic [CH_COUNT-1:0][15:0] duty_act;
    logic [CH_COUNT-1:0][7:0] channel_scale;
    logic [7:0] global_current;
    logic [7:0] phase_ctrl;
    logic [1:0] fault_detect_mode;
    logic [CH_COUNT-1:0] fault_result_bits;
    logic [1:0] thermal_threshold;
    logic [1:0] thermal_derate;
    logic thermal_flag;
    logic [7:0] spread_ctrl;
    logic [15:0] cnt;
    logic [CH_COUNT-1:0] pwm;
    logic [CH_COUNT-1:0][15:0] cur;
    reg_rsp_t rsp;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  function automatic logic [15:0] res_mask(input logic [1:0] code);
    case (code) // R23
      RES_8: res_mask = MASK_8;
      RES_10: res_mask = MASK_10;
      RES_12: res_mask = MASK_12;
      default: res_mask = MASK_16;
    endcase
  endfunction

  function automatic logic [7:0] temp_point(input logic [1:0] code);
    case (code) // R14
      2'h0: temp_point = TEMP_PT_0;
      2'h1: temp_point = TEMP_PT_1;
      2'h2: temp_point = TEMP_PT_2;
      default: temp_point = TEMP_PT_3;
    endcase
  endfunction

  function automatic logic [8:0] derate_factor(input logic [1:0] code);
    case (code) // R16
      2'h0: derate_factor = DERATE_F_0;
      2'h1: derate_factor = DERATE_F_1;
      2'h2: derate_factor = DERATE_F_2;
      default: derate_factor = DERATE_F_3;
    endcase
  endfunction

  // Register read mux at the current pointer
  function automatic logic [7:0] read_byte(input state_t s);
    logic [7:0] idx;
    logic [5:0] ch;
    logic [7:0] fb;
    idx = 8'h00;
    ch = 6'h00;
    fb = 8'h00;
    read_byte = 8'h00;
    if (s.ptr >= OFS_DUTY_FIRST && s.ptr <= OFS_DUTY_LAST)
    begin
      idx = s.ptr - OFS_DUTY_FIRST;
      ch = idx[6:1];
      read_byte = idx[0] ? s.duty_pend[ch][15:8] : s.duty_pend[ch][7:0];
    end
    else if (s.ptr >= OFS_SCALE_FIRST && s.ptr <= OFS_SCALE_LAST)
    begin
      idx = s.ptr - OFS_SCALE_FIRST;
      read_byte = s.channel_scale[idx[5:0]];
    end
    else if (s.ptr >= OFS_FAULT_FIRST && s.ptr <= OFS_FAULT_TOP)
    begin
      idx = s.ptr - OFS_FAULT_FIRST;
      for (int b = 0; b < 8; b++)
      begin
        if ((int'(idx) * 8 + b) < CH_COUNT)
        begin
          fb[b] = s.fault_result_bits[int'(idx) * 8 + b]; // R13
        end
      end
      read_byte = fb;
    end
    else
    begin
      case (s.ptr)
        OFS_GLOBAL: read_byte = s.global_current;
        OFS_PHASE: read_byte = s.phase_ctrl;
        OFS_DETECT: read_byte = {6'h00, s.fault_detect_mode};
        OFS_THERMAL:
          read_byte = {s.thermal_derate, 1'b0, s.thermal_flag, 2'h0, s.thermal_threshold};
        OFS_SPREAD: read_byte = s.spread_ctrl;
        default: read_byte = 8'h00;
      endcase
    end
  endfunction

  // Per-channel compare values, derived from active state
  logic [15:0] mask;
  logic [15:0] half;
  logic [15:0] cnt_shift;
  logic [8:0] factor;
  logic [CH_COUNT-1:0] pwm_calc;
  logic [CH_COUNT-1:0][15:0] cur_calc;

  always_comb
  begin
    mask = res_mask(duty_resolution_i);
    half = (mask >> 1) + 16'h0001;
    cnt_shift = (st_r.cnt ^ half) & mask;
    factor = derate_factor(st_r.thermal_derate);
  end

  for (genvar c = 0; c < CH_COUNT; c++)
  begin : g_ch
    localparam int PH_GRP = c / (CH_COUNT / NUM_GROUPS);
    localparam int FO_GRP = c / (CH_COUNT / FORCE_GROUPS);
    logic [15:0] duty_eff;
    logic [15:0] cmp_cnt;
    logic [15:0] peak;
    logic [24:0] derated;
    always_comb
    begin
      duty_eff = st_r.duty_act[c] & mask; // R02
      cmp_cnt = (st_r.phase_ctrl[PHASE_ON_BIT] && st_r.phase_ctrl[PH_GRP]) ?
                cnt_shift : st_r.cnt; // R09 R10 R26
      if (st_r.spread_ctrl[FORCE_LSB + FO_GRP]) // R17
      begin
        pwm_calc[c] = 1'b1;
      end
      else
      begin
        pwm_calc[c] = cmp_cnt < duty_eff; // R03 R18 R25
      end
      peak = st_r.global_current * st_r.channel_scale[c]; // R04 R07 R08
      derated = peak * factor;
      cur_calc[c] = st_r.thermal_flag ? derated[23:8] : peak; // R16
    end
  end

  always_comb
  begin
    logic [7:0] idx;
    idx = 8'h00;
    st_nxt = st_r;
    st_nxt.rsp.valid = 1'b0;
    st_nxt.cnt = (st_r.cnt + 16'h0001) & mask; // R03 R25
    st_nxt.pwm = pwm_calc;
    st_nxt.cur = cur_calc;
    st_nxt.thermal_flag = die_temp_i > temp_point(st_r.thermal_threshold); // R15
    case (st_r.fault_detect_mode) // R11 R12
      DET_SHORT: st_nxt.fault_result_bits = short_det_i;
      DET_OPEN: st_nxt.fault_result_bits = open_det_i;
      default: st_nxt.fault_result_bits = st_r.fault_result_bits;
    endcase
    if (cmd_i.addr_load)
    begin
      st_nxt.ptr = cmd_i.data;
    end
    else if (cmd_i.rd)
    begin
      st_nxt.rsp.valid = 1'b1;
      st_nxt.rsp.data = read_byte(st_r);
      st_nxt.ptr = st_r.ptr + 8'h01; // R24
    end
    else if (cmd_i.wr)
    begin
      st_nxt.ptr = st_r.ptr + 8'h01; // R24
      if (st_r.ptr >= OFS_DUTY_FIRST && st_r.ptr <= OFS_DUTY_LAST)
      begin
        idx = st_r.ptr - OFS_DUTY_FIRST;
        if (idx[0]) // R01
        begin
          st_nxt.duty_pend[idx[6:1]][15:8] = cmd_i.data;
        end
        else
        begin
          st_nxt.duty_pend[idx[6:1]][7:0] = cmd_i.data;
        end
      end
      else if (st_r.ptr >= OFS_SCALE_FIRST && st_r.ptr <= OFS_SCALE_LAST)
      begin
        idx = st_r.ptr - OFS_SCALE_FIRST;
        st_nxt.channel_scale[idx[5:0]] = cmd_i.data; // R05 R07
      end
      else
      begin
        case (st_r.ptr)
          OFS_APPLY:
            if (cmd_i.data == TRIGGER_VALUE)
            begin
              st_nxt.duty_act = st_r.duty_pend; // R06
            end
          OFS_GLOBAL: st_nxt.global_current = cmd_i.data; // R08
          OFS_PHASE: st_nxt.phase_ctrl = cmd_i.data & 8'hbf; // R09 R10
          OFS_DETECT:
          begin
            st_nxt.fault_detect_mode = cmd_i.data[1:0]; // R11
            st_nxt.fault_result_bits = '0; // R12
          end
          OFS_THERMAL:
          begin
            st_nxt.thermal_threshold = cmd_i.data[1:0]; // R14
            st_nxt.thermal_derate = cmd_i.data[DERATE_LSB +: 2]; // R16
          end
          OFS_SPREAD: st_nxt.spread_ctrl = cmd_i.data; // R17 R19 R20 R21
          OFS_SOFT_RESET:
            if (cmd_i.data == TRIGGER_VALUE)
            begin
              st_nxt = '0; // R22
            end
          default: st_nxt.ptr = st_r.ptr + 8'h01;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign rsp_o = st_r.rsp;
  assign pwm_o = st_r.pwm;
  assign current_code_o = st_r.cur;
  assign spread_enable_o = st_r.spread_ctrl[SPREAD_EN_BIT]; // R19
  assign spread_range_o = st_r.spread_ctrl[SPREAD_RANGE_LSB +: 2]; // R20
  assign spread_period_o = st_r.spread_ctrl[SPREAD_PERIOD_LSB +: 2]; // R21
endmodule

// ---- tb/led_pwm_chk_sva.sv ----
// Port assertions of the LED pulse-width register block
`timescale 1ns/10ps
module led_pwm_chk
  import led_pwm_pkg::*;
#(
  parameter int CH_COUNT = 36
)
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  // Watched ports
  input wire led_pwm_pkg::reg_cmd_t cmd_i,
  input wire led_pwm_pkg::reg_rsp_t rsp_o,
  input wire logic [CH_COUNT-1:0] pwm_o,
  input wire logic [CH_COUNT*16-1:0] current_code_o,
  input wire logic spread_enable_o,
  input wire logic [1:0] spread_range_o,
  input wire logic [1:0] spread_period_o
);
  logic [7:0] ptr_r;
  logic [7:0] spr_r;
  wire logic wr_now = cmd_i.wr && !cmd_i.addr_load && !cmd_i.rd;
  wire logic clr = wr_now && ptr_r == OFS_SOFT_RESET && cmd_i.data == TRIGGER_VALUE;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);
  // Shadow of the pointer and of 78h
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      {ptr_r, spr_r} <= '0;
    else
    begin
      ptr_r <= clr ? 8'h00 : cmd_i.addr_load ? cmd_i.data : ptr_r + {7'h0, cmd_i.rd | cmd_i.wr};
      spr_r <= clr ? 8'h00 : (wr_now && ptr_r == OFS_SPREAD) ? cmd_i.data : spr_r;
    end
  end
  property p_rd_ans;
    cmd_i.rd && !cmd_i.addr_load |=> rsp_o.valid;
  endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
  property p_rd_cause;
    rsp_o.valid |-> $past(cmd_i.rd && !cmd_i.addr_load);
  endproperty
  a_rd_cause: assert property (p_rd_cause) else $error("answer without read");
  property p_soft_rst;
    clr |=> current_code_o == '0 && pwm_o == '0 && !spread_enable_o;
  endproperty
  a_soft_rst: assert property (p_soft_rst) else $error("soft reset left state");
  property p_spr_en;
    spread_enable_o == spr_r[SPREAD_EN_BIT];
  endproperty
  a_spr_en: assert property (p_spr_en) else $error("spread enable wrong");
  property p_spr_rng;
    spread_range_o == spr_r[3:2];
  endproperty
  a_spr_rng: assert property (p_spr_rng) else $error("spread range wrong");
  property p_spr_per;
    spread_period_o == spr_r[1:0];
  endproperty
  a_spr_per: assert property (p_spr_per) else $error("spread period wrong");
  property p_force_lo;
    spr_r[5] && $past(spr_r[5]) |-> &pwm_o[11:0];
  endproperty
  a_force_lo: assert property (p_force_lo) else $error("low group not on");
  property p_force_hi;
    spr_r[7] && $past(spr_r[7]) |-> &pwm_o[35:24];
  endproperty
  a_force_hi: assert property (p_force_hi) else $error("top group not on");
  c_read: cover property (rsp_o.valid);
  c_force: cover property (&pwm_o);
  c_spread: cover property (spread_enable_o);
endmodule
bind led_pwm_current_regs led_pwm_chk #(.CH_COUNT(CH_COUNT)) i_led_pwm_chk (.clk_sys_i,
  .arst_n_i, .cmd_i, .rsp_o, .pwm_o, .current_code_o, .spread_enable_o, .spread_range_o,
  .spread_period_o);

// ---- tb/host_bfm.sv ----
// Host side command driver standing in for the serial slave
`timescale 1ns/10ps
module host_bfm
  import led_pwm_pkg::*;
(
  // Clock
  input wire logic clk_sys_i,
  // Command and answer
  output led_pwm_pkg::reg_cmd_t cmd_o,
  input wire led_pwm_pkg::reg_rsp_t rsp_i
);
  initial cmd_o = '0;
  // One command per edge, launched just after it
  task op(input logic [2:0] k, input logic [7:0] d);
    cmd_o = {k, d};
    @(posedge clk_sys_i);
    #1;
  endtask
  task idle();
    cmd_o = '0;
    @(posedge clk_sys_i);
    #1;
  endtask
  task rd(output logic [7:0] d, output logic v);
    op(3'b001, 8'h00);
    // Answer is registered on the read edge and stands just after it
    d = rsp_i.data;
    v = rsp_i.valid;
    idle();
  endtask
endmodule

// ---- tb/led_pwm_current_regs_tb.sv ----
// Self-checking bench of the LED pulse-width register block
`timescale 1ns/10ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
  $display("wrong value at %0t: %h not %h", $time, g, e); end end
module led_pwm_current_regs_tb;
  import led_pwm_pkg::*;
  logic clk_sys_i = 1'b0;
  logic arst_n_i = 1'b0;
  reg_cmd_t cmd;
  reg_rsp_t rsp;
  logic [1:0] res = RES_8;
  logic [7:0] temp = 8'h00;
  logic [35:0] opn = '0, sht = '0, pwm;
  logic [575:0] code;
  logic sen;
  logic [1:0] srg, spd;
  int n_fail = 0, cmp_count = 0, cyc = 0;
  led_pwm_current_regs #(.CH_COUNT(NUM_CH)) i_led_pwm_current_regs (.clk_sys_i, .arst_n_i,
    .cmd_i(cmd), .rsp_o(rsp), .duty_resolution_i(res), .die_temp_i(temp), .open_det_i(opn),
    .short_det_i(sht), .pwm_o(pwm), .current_code_o(code), .spread_enable_o(sen),
    .spread_range_o(srg), .spread_period_o(spd));
  host_bfm i_host_bfm (.clk_sys_i, .cmd_o(cmd), .rsp_i(rsp));
  initial
  begin
    forever #4 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      n_fail++;
      complete_run();
    end
  end
  task complete_run();
    if (n_fail == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    i_host_bfm.op(3'b100, a);
    i_host_bfm.op(3'b010, d);
    i_host_bfm.idle();
  endtask
  task rr(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic v;
    i_host_bfm.op(3'b100, a);
    i_host_bfm.rd(d, v);
    `CHK({v, d}, {1'b1, e})
  endtask
  // Cycles with channel 1 on, and with channels 1 and 7 apart
  task cnt(input int n, output int on, output int df);
    on = 0;
    df = 0;
    repeat (n)
    begin
      @(posedge clk_sys_i);
      #1;
      on += int'(pwm[0]);
      df += int'(pwm[0] ^ pwm[6]);
    end
  endtask
  task s_defaults();
    static logic [7:0] a [8] = '{8'h01, 8'h48, 8'h49, 8'h4a, 8'h6d, 8'h6e, 8'h78, 8'h79};
    foreach (a[i])
      rr(a[i], RST_BYTE);
    `CHK(code, 576'h0)
  endtask
  task s_duty();
    int on, df;
    i_host_bfm.op(3'b100, OFS_DUTY_FIRST);
    i_host_bfm.op(3'b010, 8'h80);
    i_host_bfm.op(3'b010, 8'hff);
    i_host_bfm.idle();
    rr(8'h02, 8'hff);
    wr(OFS_APPLY, 8'h01);
    cnt(256, on, df);
    `CHK(on, 0)
    wr(OFS_APPLY, TRIGGER_VALUE);
    cnt(256, on, df);
    `CHK(on, 128)
    for (int i = 1; i < 3; i++)
    begin
      res = i[1:0];
      repeat (2) cnt(256 << (2 * i), on, df);
      `CHK(on, 32'hff80 & ((256 << (2 * i)) - 1))
    end
    res = RES_8;
    cnt(4096, on, df);
  endtask
  task s_phase_force();
    static logic [7:0] ph [4] = '{8'h01, 8'h81, 8'h82, 8'h83};
    static int ex [4] = '{0, 256, 256, 0};
    int on, df;
    wr(8'h0d, 8'h80);
    wr(OFS_APPLY, TRIGGER_VALUE);
    foreach (ph[i])
    begin
      wr(OFS_PHASE, ph[i]);
      cnt(256, on, df);
      `CHK(df, ex[i])
    end
    wr(OFS_SPREAD, 8'h20);
    cnt(256, on, df);
    `CHK({on, pwm[35:12]}, {32'd256, 24'h0})
    wr(8'h01, 8'hff);
    wr(OFS_APPLY, TRIGGER_VALUE);
    wr(OFS_SPREAD, 8'h00);
    cnt(256, on, df);
    `CHK(on, 255)
    wr(OFS_SPREAD, 8'he0);
    `CHK(pwm, {36{1'b1}})
  endtask
  task s_scale();
    i_host_bfm.op(3'b100, OFS_SCALE_LAST);
    i_host_bfm.op(3'b010, 8'h07);
    i_host_bfm.op(3'b010, 8'h03);
    i_host_bfm.idle();
    `CHK(code[575:560], 16'd21)
    wr(OFS_SCALE_FIRST, 8'h05);
    `CHK(code[15:0], 16'd15)
  endtask
  task s_thermal();
    static logic [7:0] pt [4] = '{TEMP_PT_0, TEMP_PT_1, TEMP_PT_2, TEMP_PT_3};
    static logic [8:0] f [4] = '{DERATE_F_0, DERATE_F_1, DERATE_F_2, DERATE_F_3};
    for (int i = 0; i < 4; i++)
    begin
      wr(OFS_THERMAL, {i[1:0], 4'h0, i[1:0]});
      temp = pt[i];
      rr(OFS_THERMAL, {i[1:0], 4'h0, i[1:0]});
      temp = pt[i] + 8'h01;
      rr(OFS_THERMAL, {i[1:0], 4'h4, i[1:0]});
      `CHK(code[575:560], 16'((21 * f[i]) >> 8))
    end
  endtask
  task s_fault();
    sht = 36'h800000001;
    opn = 36'h000000002;
    wr(OFS_DETECT, {6'h0, DET_SHORT});
    rr(OFS_FAULT_FIRST, 8'h01);
    rr(OFS_FAULT_TOP, 8'h08);
    wr(OFS_DETECT, {6'h0, DET_OPEN});
    rr(OFS_FAULT_FIRST, 8'h02);
    wr(OFS_DETECT, 8'h01);
    wr(OFS_FAULT_FIRST, 8'hff);
    rr(OFS_FAULT_FIRST, 8'h00);
  endtask
  task s_spread();
    for (int i = 0; i < 4; i++)
    begin
      wr(OFS_SPREAD, {4'h1, i[1:0], i[1:0]});
      `CHK({sen, srg, spd}, {1'b1, i[1:0], i[1:0]})
    end
    wr(OFS_SOFT_RESET, 8'h01);
    rr(OFS_SPREAD, 8'h1f);
    wr(OFS_SOFT_RESET, TRIGGER_VALUE);
    rr(OFS_SPREAD, RST_BYTE);
    `CHK({sen, code}, 577'h0)
  endtask
  initial
  begin
    repeat (4) @(posedge clk_sys_i);
    #1;
    arst_n_i = 1'b1;
    s_defaults();
    s_duty();
    s_phase_force();
    s_scale();
    s_thermal();
    s_fault();
    s_spread();
    complete_run();
  end
endmodule
